//--- rtl/usd_top.sv
// device state, default-pipe control stages, frames and pipe settings
// assumes link events come from protocol logic on clk_sys, one-cycle pulses
module usd_top #(
  parameter int UFRAME_CYC = usd_pkg::UFRAME_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ev_bus_reset,
  input wire logic ev_reset_done,
  input wire logic ev_suspend,
  input wire logic ev_resume,
  input wire logic ev_set_address,
  input wire logic ev_set_config,
  input wire logic config_nonzero,
  input wire logic ev_setup,
  input wire logic setup_dir_in,
  input wire logic setup_has_data,
  input wire logic tok_in,
  input wire logic tok_out,
  input wire logic tok_ping,
  input wire logic data_rx,
  input wire logic data_pid1,
  input wire logic in_data_acked,
  input wire logic out_data_acked,
  input wire logic hs_mode,
  input wire logic sof_valid,
  input wire logic sof_ok,
  input wire logic [10:0] sof_frame,
  output logic [1:0] dcp_pid,
  output logic setup_ack,
  output logic intr_req,
  output logic sof_locked
);
  import usd_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_DATA, ST_RD_STAT, ST_WR_DATA, ST_WR_STAT, ST_ND_STAT,
    ST_ERR
  } usd_stage_t;

  typedef enum logic [2:0] {
    DV_POWERED, DV_DEFAULT, DV_ADDRESS, DV_CONFIG, DV_SUSPEND
  } usd_dev_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic enable;
    logic [3:0] ists;
    logic [7:0] ien;
    logic sequence_error_flag;
    logic err_hold;
    logic ct_pend;
    usd_stage_t stage;
    logic moved;
    logic first;
    logic [1:0] pid;
    logic setup_ack;
    usd_dev_t dev;
    usd_dev_t saved;
    logic rst_pend;
    logic [3:0] psel;
    logic [9:0][15:0] cfg;
    logic [9:0][4:0] bsz;
    logic [9:0][7:0] area;
    logic [9:0][10:0] max_packet_size_field;
    logic [9:0][12:0] peri;
    logic [9:0][15:0] pctl;
    logic intr;
  } usd_st_t;

  usd_st_t s, next_s;
  usd_sof_if sif ();

  // ----------------------------------------------------------------
  // sof lock monitor
  // ----------------------------------------------------------------
  assign sif.enable = s.enable;
  assign sif.bus_reset = ev_bus_reset;
  assign sif.suspended = (s.dev == DV_SUSPEND);
  assign sif.hs_mode = hs_mode;
  assign sif.sof_valid = sof_valid;
  assign sif.sof_ok = sof_ok;
  assign sif.sof_frame = sof_frame;

  usd_sof_mon #(.UFRAME_CYC(UFRAME_CYC)) u_sof (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sof(sif)
  );

  function automatic logic [2:0] stage_code(input usd_stage_t st);
    case (st)
      ST_RD_DATA: stage_code = 3'h1;
      ST_RD_STAT: stage_code = 3'h2;
      ST_WR_DATA: stage_code = 3'h3;
      ST_WR_STAT: stage_code = 3'h4;
      ST_ND_STAT: stage_code = 3'h5;
      ST_ERR: stage_code = CT_ERR;
      default: stage_code = 3'h0;
    endcase
  endfunction : stage_code

  function automatic logic [2:0] dev_code(input usd_dev_t d);
    case (d)
      DV_DEFAULT: dev_code = 3'h1;
      DV_ADDRESS: dev_code = 3'h2;
      DV_CONFIG: dev_code = 3'h3;
      DV_SUSPEND: dev_code = 3'h4;
      default: dev_code = 3'h0;
    endcase
  endfunction : dev_code

  logic wr_en;
  logic rd_en;
  logic [3:0] p;
  logic pval;
  logic mid;
  logic bulk_ok;
  logic iso_ok;
  logic err_now;
  logic [3:0] cause;
  logic cause_set;
  logic clr_control_stage_irq;
  logic [3:0] set_vec;
  logic [3:0] clr_vec;
  logic [15:0] wcfg;
  logic [15:0] wctl;
  logic [31:0] rd;
  logic hit;
  logic [1:0] ntype;

  always_comb begin
    next_s = s;
    next_s.setup_ack = 1'b0;
    wr_en = psel && penable && s.pready && pwrite;
    rd_en = psel && penable && !s.pready;
    p = s.psel;
    pval = (p < NPIPE);
    mid = (p >= 4'h1) && (p <= 4'h5);
    bulk_ok = (p >= 4'h3) && (p <= 4'h5);
    iso_ok = 1'b0;
    err_now = 1'b0;
    cause = 4'h0;
    set_vec = 4'h0;
    clr_vec = 4'h0;
    wcfg = 16'h0000;
    wctl = 16'h0000;
    rd = 32'h0000_0000;
    hit = 1'b1;
    ntype = 2'h0;
    if (pval) begin
      ntype = s.cfg[p][CF_TYPE +: 2];
    end

    // ----------------------------------------------------------------
    // device state
    // ----------------------------------------------------------------
    if (ev_bus_reset) begin
      next_s.rst_pend = 1'b1;
      next_s.stage = ST_IDLE;
    end else if (ev_reset_done && s.rst_pend) begin
      next_s.rst_pend = 1'b0;
      next_s.dev = DV_DEFAULT;
      set_vec[IS_DVST] = 1'b1;
    end else if (ev_suspend && s.dev != DV_SUSPEND) begin
      next_s.saved = s.dev;
      next_s.dev = DV_SUSPEND;
      set_vec[IS_DVST] = 1'b1;
    end else if (ev_resume && s.dev == DV_SUSPEND) begin
      next_s.dev = s.saved;
      set_vec[IS_RESM] = 1'b1;
    end else if (ev_set_address && s.dev == DV_DEFAULT) begin
      next_s.dev = DV_ADDRESS;
      set_vec[IS_DVST] = 1'b1;
    end else if (ev_set_config && s.dev != DV_SUSPEND &&
                 s.dev != DV_POWERED) begin
      next_s.dev = config_nonzero ? DV_CONFIG : DV_ADDRESS;
      set_vec[IS_DVST] = 1'b1;
    end

    // ----------------------------------------------------------------
    // control transfer stages
    // ----------------------------------------------------------------
    // cause bits: 0 setup done, 1 status stage, 2 end, 3 error
    if (ev_setup) begin
      next_s.setup_ack = 1'b1;
      next_s.pid = PID_NAK;
      next_s.moved = 1'b0;
      next_s.first = 1'b1;
      cause[0] = 1'b1;
      if (!setup_has_data) begin
        next_s.stage = ST_ND_STAT;
      end else if (setup_dir_in) begin
        next_s.stage = ST_RD_DATA;
      end else begin
        next_s.stage = ST_WR_DATA;
      end
    end else begin
      case (s.stage)
        ST_RD_DATA: begin
          if (in_data_acked) begin
            next_s.moved = 1'b1;
          end else if (tok_out || tok_ping) begin
            if (!s.moved) begin
              err_now = 1'b1;
            end else begin
              next_s.stage = ST_RD_STAT;
              cause[1] = 1'b1;
            end
          end
        end
        ST_RD_STAT: begin
          if (tok_in) begin
            err_now = 1'b1;
          end else if (data_rx && !data_pid1) begin
            err_now = 1'b1;
          end else if (data_rx) begin
            // any length is accepted here and completes the transfer
            next_s.stage = ST_IDLE;
            cause[2] = 1'b1;
          end
        end
        ST_WR_DATA: begin
          // received length is never compared with the request length
          if (data_rx && s.first && !data_pid1) begin
            err_now = 1'b1;
          end else if (data_rx) begin
            next_s.first = 1'b0;
          end
          if (out_data_acked) begin
            next_s.moved = 1'b1;
          end else if (tok_in) begin
            if (!s.moved) begin
              err_now = 1'b1;
            end else begin
              next_s.stage = ST_WR_STAT;
              cause[1] = 1'b1;
            end
          end
        end
        ST_WR_STAT, ST_ND_STAT: begin
          if (tok_out || tok_ping) begin
            err_now = 1'b1;
          end else if (in_data_acked) begin
            next_s.stage = ST_IDLE;
            cause[2] = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (err_now) begin
      next_s.stage = ST_ERR;
      next_s.pid = PID_STALL;
      next_s.sequence_error_flag = 1'b1;
      cause = 4'h8;
    end
    cause_set = |(cause & s.ien[IE_CAUSE +: 4]);
    clr_control_stage_irq = wr_en && paddr == A_ISTS && !pwdata[IS_CONTROL_STAGE_IRQ];
    // error code is held and later causes wait for the software clear
    if (err_now) begin
      next_s.err_hold = 1'b1;
      set_vec[IS_CONTROL_STAGE_IRQ] = 1'b1;
      next_s.ct_pend = 1'b0;
    end else if (s.err_hold && !clr_control_stage_irq) begin
      next_s.ct_pend = s.ct_pend || cause_set;
    end else if (s.err_hold) begin
      next_s.err_hold = 1'b0;
      next_s.sequence_error_flag = 1'b0;
      next_s.ct_pend = 1'b0;
      set_vec[IS_CONTROL_STAGE_IRQ] = s.ct_pend || cause_set;
    end else begin
      set_vec[IS_CONTROL_STAGE_IRQ] = cause_set;
    end
    set_vec[IS_FRAME_UPDATE_IRQ] = sif.update;

    // ----------------------------------------------------------------
    // apb writes
    // ----------------------------------------------------------------
    if (wr_en) begin
      if (paddr == A_SYS) begin
        next_s.enable = pwdata[0];
      end else if (paddr == A_ISTS) begin
        clr_vec = ~pwdata[3:0];
      end else if (paddr == A_IEN) begin
        next_s.ien = pwdata[7:0];
      end else if (paddr == A_DCPCTL) begin
        next_s.pid = pwdata[1:0];
      end else if (paddr == A_PSEL) begin
        next_s.psel = pwdata[3:0];
      end else if (pval && paddr == A_PCFG && mid) begin
        wcfg = pwdata[15:0];
        // continuous mode is only offered where software can size the
        // buffer as whole packets; sizing it so stays software's job
        bulk_ok = wcfg[CF_TYPE +: 2] == TY_BULK;
        wcfg[CF_CONTINUOUS_MODE_SELECT] = wcfg[CF_CONTINUOUS_MODE_SELECT] && (p >= 4'h3 || bulk_ok);
        wcfg[CF_DISABLE_ON_COMPLETION] = wcfg[CF_DISABLE_ON_COMPLETION] && (p >= 4'h3 || bulk_ok);
        next_s.cfg[p] = wcfg;
        if (p <= 4'h2 && wcfg[CF_TYPE +: 2] != TY_ISO) begin
          next_s.peri[p] = 13'h0000;
        end
      end else if (pval && paddr == A_PCFG && p == 4'h0) begin
        next_s.cfg[0][CF_DISABLE_ON_COMPLETION] = pwdata[CF_DISABLE_ON_COMPLETION];
      end else if (pval && paddr == A_PCFG) begin
        next_s.cfg[p][3:0] = pwdata[3:0];
      end else if (pval && paddr == A_PBUF && mid) begin
        next_s.bsz[p] = pwdata[BF_SIZE +: 5];
        if (pwdata[7:0] >= AREA_MIN && pwdata[7:0] <= AREA_MAX) begin
          next_s.area[p] = pwdata[7:0];
        end
      end else if (pval && paddr == A_PMAXP) begin
        next_s.max_packet_size_field[p] = pwdata[10:0];
      end else if (pval && paddr == A_PPERI) begin
        iso_ok = p >= 4'h1 && p <= 4'h2 && ntype == TY_ISO;
        if (iso_ok) begin
          next_s.peri[p] = pwdata[12:0];
        end
      end else if (pval && paddr == A_PCTL) begin
        wctl = pwdata[15:0];
        wctl[PC_AUTO_RESPONSE_MODE] = wctl[PC_AUTO_RESPONSE_MODE] && mid;
        next_s.pctl[p] = wctl;
      end
    end
    next_s.ists = (s.ists & ~clr_vec) | set_vec;

    // ----------------------------------------------------------------
    // apb reads, one wait state so the answer comes from flops
    // ----------------------------------------------------------------
    if (paddr == A_SYS) begin
      rd[0] = s.enable;
    end else if (paddr == A_ISTS) begin
      rd[3:0] = s.ists;
      rd[IS_CONTROL_STAGE_FIELD +: 3] = s.err_hold ? CT_ERR : stage_code(s.stage);
      rd[IS_SEQUENCE_ERROR_FLAG] = s.sequence_error_flag;
      rd[IS_DEVICE_STATE_FIELD +: 3] = dev_code(s.dev);
    end else if (paddr == A_IEN) begin
      rd[7:0] = s.ien;
    end else if (paddr == A_FRM) begin
      rd[10:0] = sif.frame;
      rd[FR_LOCK] = sif.locked;
    end else if (paddr == A_DCPCTL) begin
      rd[1:0] = s.pid;
    end else if (paddr == A_PSEL) begin
      rd[3:0] = s.psel;
    end else if (paddr == A_PCFG) begin
      if (pval) begin
        rd[15:0] = s.cfg[p];
      end
    end else if (paddr == A_PBUF) begin
      if (p == 4'h0) begin
        rd[BF_SIZE +: 5] = DCP_BUFSZ;
        rd[7:0] = DCP_AREA;
      end else if (mid) begin
        rd[BF_SIZE +: 5] = s.bsz[p];
        rd[7:0] = s.area[p];
      end else if (pval) begin
        rd[BF_SIZE +: 5] = SMALL_BUFSZ;
        rd[7:0] = SMALL_AREA + {4'h0, p} - 8'h06;
      end
    end else if (paddr == A_PMAXP) begin
      if (pval) begin
        rd[10:0] = s.max_packet_size_field[p];
      end
    end else if (paddr == A_PPERI) begin
      if (pval) begin
        rd[12:0] = s.peri[p];
      end
    end else if (paddr == A_PCTL) begin
      if (pval) begin
        rd[15:0] = s.pctl[p];
      end
    end else begin
      hit = 1'b0;
    end
    if (rd_en) begin
      next_s.prdata = rd;
      next_s.pslverr = !hit;
      next_s.pready = 1'b1;
    end else begin
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
    end
    // masks gate the sticky status onto the request line
    next_s.intr = |(next_s.ists & s.ien[3:0]);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign dcp_pid = s.pid;
  assign setup_ack = s.setup_ack;
  assign intr_req = s.intr;
  assign sof_locked = sif.locked;
endmodule : usd_top

//--- rtl/usd_pkg.sv
// shared constants of the usb device state and default-pipe control block
// assumes a 125 MHz system clock and a 32-bit apb register port
package usd_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 8;
  localparam int UFRAME_NS = 125000;
  localparam int UFRAME_CYC = UFRAME_NS / CLK_NS;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_SYS = 8'h00;
  localparam logic [7:0] A_ISTS = 8'h04;
  localparam logic [7:0] A_IEN = 8'h08;
  localparam logic [7:0] A_FRM = 8'h0C;
  localparam logic [7:0] A_DCPCTL = 8'h10;
  localparam logic [7:0] A_PSEL = 8'h14;
  localparam logic [7:0] A_PCFG = 8'h18;
  localparam logic [7:0] A_PBUF = 8'h1C;
  localparam logic [7:0] A_PMAXP = 8'h20;
  localparam logic [7:0] A_PPERI = 8'h24;
  localparam logic [7:0] A_PCTL = 8'h28;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int IS_DVST = 0;
  localparam int IS_CONTROL_STAGE_IRQ = 1;
  localparam int IS_FRAME_UPDATE_IRQ = 2;
  localparam int IS_RESM = 3;
  localparam int IS_CONTROL_STAGE_FIELD = 4;
  localparam int IS_SEQUENCE_ERROR_FLAG = 7;
  localparam int IS_DEVICE_STATE_FIELD = 8;
  localparam int IE_CAUSE = 4;
  localparam int FR_LOCK = 12;
  localparam int CF_TYPE = 14;
  localparam int CF_READY_IRQ_MODE = 10;
  localparam int CF_DOUBLE_BUFFER_SELECT = 9;
  localparam int CF_CONTINUOUS_MODE_SELECT = 8;
  localparam int CF_DISABLE_ON_COMPLETION = 7;
  localparam int BF_SIZE = 10;
  localparam int PE_ISO_BUFFER_FLUSH = 12;
  localparam int PC_AUTO_RESPONSE_MODE = 10;
  localparam int PC_AUTO_BUFFER_CLEAR = 9;
  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] PID_NAK = 2'h0;
  localparam logic [1:0] PID_STALL = 2'h2;
  localparam logic [1:0] TY_BULK = 2'h1;
  localparam logic [1:0] TY_INT = 2'h2;
  localparam logic [1:0] TY_ISO = 2'h3;
  localparam logic [2:0] CT_ERR = 3'h6;
  localparam logic [4:0] DCP_BUFSZ = 5'h03;
  localparam logic [4:0] SMALL_BUFSZ = 5'h00;
  localparam logic [7:0] DCP_AREA = 8'h00;
  localparam logic [7:0] SMALL_AREA = 8'h04;
  localparam logic [7:0] AREA_MIN = 8'h08;
  localparam logic [7:0] AREA_MAX = 8'h87;
  localparam logic [3:0] NPIPE = 4'hA;
endpackage : usd_pkg

//--- rtl/usd_sof_if.sv
// signals between the control core and the sof lock monitor
// assumes both ends run on clk_sys
interface usd_sof_if;
  logic enable;
  logic bus_reset;
  logic suspended;
  logic hs_mode;
  logic sof_valid;
  logic sof_ok;
  logic [10:0] sof_frame;
  logic [10:0] frame;
  logic [2:0] uframe;
  logic locked;
  logic update;
  modport mon (input enable, bus_reset, suspended, hs_mode, sof_valid,
    sof_ok, sof_frame, output frame, uframe, locked, update);
  modport ctl (output enable, bus_reset, suspended, hs_mode, sof_valid,
    sof_ok, sof_frame, input frame, uframe, locked, update);
endinterface : usd_sof_if

//--- rtl/usd_sof_mon.sv
// frame number tracking and microframe sof lock monitor
// assumes sof events arrive as one-cycle pulses on clk_sys
module usd_sof_mon #(
  parameter int UFRAME_CYC = usd_pkg::UFRAME_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  usd_sof_if.mon sof
);
  import usd_pkg::*;

  localparam logic [13:0] TMAX = 14'(UFRAME_CYC - 1);

  typedef struct packed {
    logic have;
    logic locked;
    logic [10:0] last;
    logic [10:0] frame;
    logic [2:0] uframe;
    logic update;
    logic [13:0] tmr;
  } usd_sof_st_t;

  usd_sof_st_t s, next_s;
  logic stop;
  logic good;

  always_comb begin
    next_s = s;
    next_s.update = 1'b0;
    stop = !sof.enable || sof.bus_reset || sof.suspended;
    good = sof.sof_valid && sof.sof_ok;
    if (stop) begin
      next_s.have = 1'b0;
      next_s.locked = 1'b0;
      next_s.tmr = '0;
    end else if (good && !sof.hs_mode) begin
      next_s.frame = sof.sof_frame;
      next_s.update = 1'b1;
    end else if (good) begin
      next_s.tmr = '0;
      next_s.have = 1'b1;
      next_s.last = sof.sof_frame;
      if (s.have && sof.sof_frame != s.last) begin
        next_s.locked = 1'b1;
      end
      next_s.uframe = (sof.sof_frame != s.last) ? 3'h0 : s.uframe + 3'h1;
      if (next_s.locked && sof.sof_frame != s.frame) begin
        next_s.frame = sof.sof_frame;
        next_s.update = 1'b1;
      end
    end else if (sof.hs_mode && s.locked) begin
      // a missed microframe sof is interpolated only once locked
      if (s.tmr == TMAX) begin
        next_s.tmr = '0;
        next_s.uframe = s.uframe + 3'h1;
        if (s.uframe == 3'h7) begin
          next_s.frame = s.frame + 11'h001;
          next_s.update = 1'b1;
        end
      end else begin
        next_s.tmr = s.tmr + 14'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sof.frame = s.frame;
  assign sof.uframe = s.uframe;
  assign sof.locked = s.locked;
  assign sof.update = s.update;
endmodule : usd_sof_mon

//--- testbench/usd_host.sv
// host-side link model: one-cycle event pulses toward the device
// assumes the bench calls pulse() right after a rising clk_sys edge
module usd_host (
  input wire logic clk_sys,
  output logic [13:0] ev
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ev = '0;
  // one event per call, then a quiet cycle, so events never overlap
  task automatic pulse(input int n);
    @(posedge clk_sys);
    ev <= 14'h1 << n;
    @(posedge clk_sys);
    ev <= '0;
  endtask : pulse
endmodule : usd_host

//--- testbench/usd_top_asserts.sv
// concurrent checks on the ports of usd_top, attached by bind
// assumes one clock domain, clk_sys, with rst_n active low
module usd_top_asserts (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ev_bus_reset,
  input wire logic ev_setup,
  input wire logic setup_has_data,
  input wire logic tok_out,
  input wire logic tok_ping,
  input wire logic in_data_acked,
  input wire logic hs_mode,
  input wire logic sof_valid,
  input wire logic sof_ok,
  input wire logic [1:0] dcp_pid,
  input wire logic setup_ack,
  input wire logic sof_locked
);
  import usd_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // software writes to the response field may legally undo a stall
  wire dcp_wr = psel && pwrite && paddr == A_DCPCTL;
  logic nd_stat;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n) nd_stat <= 1'b0;
    else if (ev_setup) nd_stat <= !setup_has_data;
    else if (ev_bus_reset || in_data_acked || dcp_wr) nd_stat <= 1'b0;
  property p_setup_ack; ev_setup |=> setup_ack ##1 !setup_ack; endproperty
  a_setup_ack: assert property (p_setup_ack) else $error("no setup ack");
  property p_setup_nak; ev_setup |=> dcp_pid == PID_NAK; endproperty
  a_setup_nak: assert property (p_setup_nak) else $error("no nak");
  property p_stall;
    nd_stat && (tok_out || tok_ping) && !ev_setup && !dcp_wr
      |=> dcp_pid == PID_STALL;
  endproperty
  a_stall: assert property (p_stall) else $error("no stall");
  property p_lock; $rose(sof_locked) |-> $past(sof_valid && sof_ok && hs_mode);
  endproperty
  a_lock: assert property (p_lock) else $error("lock w/o sof");
  property p_unlock; ev_bus_reset |=> !sof_locked; endproperty
  a_unlock: assert property (p_unlock) else $error("lock kept");
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("slow pready");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long pready");
  property p_err; pslverr |-> pready && psel && penable; endproperty
  a_err: assert property (p_err) else $error("stray pslverr");
  c_setup: cover property (ev_setup ##1 setup_ack);
  c_lock: cover property ($rose(sof_locked));
  c_stall: cover property (dcp_pid == PID_STALL);
endmodule : usd_top_asserts
bind usd_top usd_top_asserts u_usd_top_asserts (.clk_sys, .rst_n, .psel,
  .penable, .pwrite, .paddr, .pready, .pslverr, .ev_bus_reset, .ev_setup,
  .setup_has_data, .tok_out, .tok_ping, .in_data_acked, .hs_mode,
  .sof_valid, .sof_ok, .dcp_pid, .setup_ack, .sof_locked);

//--- testbench/usd_top_bench.sv
// self-checking bench of usd_top: apb master, host model, read checker
// assumes usd_pkg, usd_host and the bound checker are compiled first
module usd_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import usd_pkg::*;
  logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, dir_in = 0, has_data = 0, pid1 = 0;
  logic hs = 0, sok = 0, cfg_nz = 0, setup_ack, intr_req, sof_locked;
  logic [10:0] frm = '0, f;
  logic [13:0] ev;
  logic [1:0] dcp_pid;
  logic [32:0] exp_q[$], msk_q[$];
  logic [23:0] t;
  logic [43:0] p;
  int err_total = 0, check_count = 0;
  // {has_data,dir_in}, stage, then up to four events, lowest first
  logic [23:0] ctl_tab [9] = '{24'h060003, 24'h360002, 24'h360124,
    24'h360624, 24'h300724, 24'h260001, 24'h260006, 24'h263157, 24'h235757};
  logic [43:0] pipe_tab [8] = '{{4'h0, A_PBUF, 16'hFFFF, 16'h0C00},
    {4'h7, A_PBUF, 16'hFFFF, 16'h0005}, {4'h2, A_PBUF, 16'h1420, 16'h1420},
    {4'h2, A_PBUF, 16'h1488, 16'h1420}, {4'h3, A_PPERI, 16'h1000, 16'h0},
    {4'h1, A_PCFG, 16'h8100, 16'h0000}, {4'h7, A_PCFG, 16'h0703, 16'h0003},
    {4'h0, A_PCFG, 16'h0080, 16'h0080}};
  usd_host u_usd_host (.clk_sys(clk_sys), .ev(ev));
  usd_top #(.UFRAME_CYC(20)) u_usd_top (.clk_sys(clk_sys), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ev_bus_reset(ev[0]), .ev_reset_done(ev[1]), .ev_suspend(ev[2]),
    .ev_resume(ev[3]), .ev_set_address(ev[4]), .ev_set_config(ev[5]),
    .config_nonzero(cfg_nz), .ev_setup(ev[6]), .setup_dir_in(dir_in),
    .setup_has_data(has_data), .tok_in(ev[7]), .tok_out(ev[8]),
    .tok_ping(ev[9]), .data_rx(ev[10]), .data_pid1(pid1),
    .in_data_acked(ev[11]), .out_data_acked(ev[12]), .hs_mode(hs),
    .sof_valid(ev[13]), .sof_ok(sok), .sof_frame(frm), .dcp_pid(dcp_pid),
    .setup_ack(setup_ack), .intr_req(intr_req), .sof_locked(sof_locked));
  initial forever #4 clk_sys = ~clk_sys;
  // ----------------------------------------------------------------
  // bus tasks and result checker
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [32:0] e, input logic [32:0] m);
    int n = 0;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
    apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
  endtask : rd
  task automatic dev(input int n, input logic [31:0] e);
    wr(A_ISTS, 32'h0);
    u_usd_host.pulse(n);
    rd(A_ISTS, e, 32'h70D);
  endtask : dev
  task automatic tok(input logic [3:0] c);
    pid1 <= (c == 4'h7);
    u_usd_host.pulse(c < 4 ? c + 6 : c < 6 ? c + 7 : 10);
  endtask : tok
  always @(posedge clk_sys) if (pready === 1'b1) begin : watch
    logic [32:0] e, m;
    e = exp_q.pop_front();
    m = msk_q.pop_front();
    check_count++;
    if ((({pslverr, prdata} ^ e) & m) !== 33'h0) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, {pslverr, prdata}, e);
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  initial begin
    #100us;
    err_total++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h24DC));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(A_ISTS, 32'h0, 32'hFFFFFFFF);
    apb(1'b0, 8'h3C, 32'h0, {1'b1, 32'h0}, {33{1'b1}});
    wr(A_SYS, 32'h1);
    wr(A_IEN, 32'hFF);
    cfg_nz <= 1'b1;
    dev(0, 32'h000);
    dev(1, 32'h101);
    dev(4, 32'h201);
    dev(5, 32'h301);
    dev(2, 32'h401);
    dev(3, 32'h308);
    // stage code must stay at error while a new request arrives
    u_usd_host.pulse(6);
    tok(4'h3);
    has_data <= 1'b1;
    dir_in <= 1'b1;
    u_usd_host.pulse(6);
    rd(A_ISTS, 32'hE0, 32'hF0);
    wr(A_ISTS, 32'h0);
    rd(A_ISTS, 32'h12, 32'hF2);
    foreach (ctl_tab[i]) begin
      t = ctl_tab[i];
      has_data <= t[21];
      dir_in <= t[20];
      u_usd_host.pulse(6);
      for (int k = 0; k < 4; k++) if (t[4*k +: 4] != 0) tok(t[4*k +: 4]);
      rd(A_ISTS, {25'h0, t[18:16], 4'h0}, 32'h70);
      rd(A_DCPCTL, t[18:16] == CT_ERR ? 32'h2 : 32'h0, 32'h3);
      wr(A_ISTS, 32'h0);
    end
    foreach (pipe_tab[i]) begin
      p = pipe_tab[i];
      wr(A_PSEL, {28'h0, p[43:40]});
      wr(p[39:32], {16'h0, p[31:16]});
      rd(p[39:32], {16'h0, p[15:0]}, 32'h3FFF);
    end
    f = 11'($urandom);
    frm <= f;
    sok <= 1'b1;
    u_usd_host.pulse(13);
    rd(A_FRM, {21'h0, f}, 32'h17FF);
    hs <= 1'b1;
    frm <= f + 11'h1;
    u_usd_host.pulse(13);
    rd(A_FRM, {21'h0, f}, 32'h17FF);
    frm <= f + 11'h2;
    u_usd_host.pulse(13);
    rd(A_FRM, {19'h0, 2'b10, f + 11'h2}, 32'h17FF);
    u_usd_host.pulse(0);
    rd(A_FRM, 32'h0, 32'h1000);
    stop_test();
  end
endmodule : usd_top_bench
